// ==== hdl/mac_pkg.sv ====
package mac_pkg;

  // Period of the system clock in ns
  localparam int CLK_PERIOD_NS      = 8;
  // Break-before-make time from select fall to channel switch-on
  localparam int SWITCH_ON_DELAY_NS = 1000;
  // Least time, so rounded up to whole cycles
  localparam int SWITCH_ON_CYCLES   =
    (SWITCH_ON_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Serial word and result geometry
  localparam int WORD_BITS   = 4;
  localparam int ADDR_BITS   = 3;
  localparam int RESULT_BITS = 12;
  localparam int GATE_POS    = 3;
  // Falling shift-clock edge (counted from 0) at which hold happens
  localparam logic [1:0] HOLD_FALL_IDX = 2'h1;

  // Wishbone register byte offsets
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  // Control fields and reset value
  localparam int         CTRL_ENABLE_POS = 0;
  localparam logic [0:0] CTRL_RESET      = 1'h1;

  // Converter sequencer states
  typedef enum logic [1:0] {
    MAC_IDLE    = 2'b00,
    MAC_SAMPLE  = 2'b01,
    MAC_CONVERT = 2'b10,
    MAC_TRAIL   = 2'b11
  } mac_state_t;

  // Pins arriving from outside the clock domain
  typedef struct packed {
    logic shift_clock;
    logic selector_select_n;
    logic converter_select_n;
    logic data_in;
    logic comparator;
  } mac_pins_t;

  // Controls towards the analog core
  typedef struct packed {
    logic bias_on;
    logic ref_connect;
    logic sample;
    logic cap_to_return;
  } mac_analog_t;

endpackage

// ==== hdl/mac_sync.sv ====
// Two-stage synchroniser for asynchronous pins
module mac_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // First stage is read by the second stage only
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Plain two-flop chain, no logic in between
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // mac_sync

// ==== hdl/mac_chan_decode.sv ====
// Channel address decoder with gate bit and channel count limit
module mac_chan_decode
  import mac_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rst_n_i,
  // Latched word and switch-on permission
  input  wire logic [WORD_BITS-1:0]    word_i,
  input  wire logic                    on_i,
  // One enable per selector input
  output logic      [NUM_CHANNELS-1:0] chan_en_o
);

  // Registered enables keep glitches off the analog switches
  logic [NUM_CHANNELS-1:0] en_reg;
  logic [NUM_CHANNELS-1:0] en_next;

  // One comparator per channel; codes above the count select nothing
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++)
    begin : g_chan
      always_comb
      begin
        en_next[g] = on_i && word_i[GATE_POS] &&
          (word_i[ADDR_BITS-1:0] == ADDR_BITS'(g));
      end
    end
  endgenerate

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      en_reg <= '0;
    else
      en_reg <= en_next;
  end

  assign chan_en_o = en_reg;

endmodule // mac_chan_decode

// ==== hdl/mac_serial_ctrl.sv ====
// Implementation choices: the Wishbone slave port and the register offsets.
module mac_serial_ctrl
  import mac_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // Clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  // Serial link pins and comparator, all asynchronous
  input  wire mac_pkg::mac_pins_t         pins_i,
  output logic                            data_out_o,
  output logic                            data_oe_o,
  // Analog core controls
  output mac_pkg::mac_analog_t            analog_o,
  output logic [mac_pkg::RESULT_BITS-1:0] trial_code_o,
  output logic [NUM_CHANNELS-1:0]         chan_en_o,
  // Classic Wishbone slave
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  input  wire logic                       wb_we_i,
  input  wire logic [3:0]                 wb_adr_i,
  input  wire logic [3:0]                 wb_sel_i,
  input  wire logic [31:0]                wb_dat_i,
  output logic [31:0]                     wb_dat_o,
  output logic                            wb_ack_o
);
  import mac_pkg::*;

  // Selects rest high; the chain carries them inverted so that its
  // cleared state reads as idle and no false fall follows reset
  localparam mac_pins_t PIN_FLIP = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  // Synchronised pins, before and after undoing the inversion
  mac_pins_t pins_flip;
  mac_pins_t pins_s;

  mac_sync #(
    .WIDTH ($bits(mac_pins_t))
  ) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .async_i (pins_i ^ PIN_FLIP),
    .sync_o  (pins_flip)
  );

  assign pins_s = pins_flip ^ PIN_FLIP;

  // Previous synchronised levels for edge detection
  logic sclk_prev_reg;
  logic sel_prev_reg;
  logic conv_prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic sel_fall;
  logic conv_fall;

  // Edge history registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_prev_reg <= 1'b0;
      sel_prev_reg  <= 1'b1;
      conv_prev_reg <= 1'b1;
    end
    else
    begin
      sclk_prev_reg <= pins_s.shift_clock;
      sel_prev_reg  <= pins_s.selector_select_n;
      conv_prev_reg <= pins_s.converter_select_n;
    end
  end

  // Edges seen in the system clock domain
  logic ctrl_enable;
  assign sclk_rise = pins_s.shift_clock && !sclk_prev_reg;
  assign sclk_fall = !pins_s.shift_clock && sclk_prev_reg;
  assign sel_fall  = sel_prev_reg && !pins_s.selector_select_n;
  assign conv_fall = conv_prev_reg && !pins_s.converter_select_n &&
                     ctrl_enable;

  // Selector state: shift word, latched word, switch-on delay
  logic [WORD_BITS-1:0] word_reg;
  logic [WORD_BITS-1:0] word_next;
  logic [WORD_BITS-1:0] latched_reg;
  logic [WORD_BITS-1:0] latched_next;
  logic [7:0]           chan_dly_reg;
  logic [7:0]           chan_dly_next;
  logic                 chan_on_reg;
  logic                 chan_on_next;

  // Selector next state
  always_comb
  begin
    word_next     = word_reg;
    latched_next  = latched_reg;
    chan_dly_next = chan_dly_reg;
    chan_on_next  = chan_on_reg;
    // Only the last four rising-edge bits survive
    if (pins_s.selector_select_n && sclk_rise)
      word_next = {word_reg[WORD_BITS-2:0], pins_s.data_in};
    if (sel_fall)
    begin
      // Gate bit lands in the top position, address below
      latched_next  = word_reg;
      // Break before make: everything off first
      chan_on_next  = 1'b0;
      chan_dly_next = 8'(SWITCH_ON_CYCLES);
    end
    else if (!chan_on_reg && chan_dly_reg != 8'h00)
    begin
      chan_dly_next = chan_dly_reg - 8'h01;
      if (chan_dly_reg == 8'h01)
        chan_on_next = 1'b1;
    end
  end

  // Selector registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      word_reg     <= '0;
      latched_reg  <= '0;
      chan_dly_reg <= 8'h00;
      chan_on_reg  <= 1'b0;
    end
    else
    begin
      word_reg     <= word_next;
      latched_reg  <= latched_next;
      chan_dly_reg <= chan_dly_next;
      chan_on_reg  <= chan_on_next;
    end
  end

  // Channel stays on until the next selector select fall
  mac_chan_decode #(
    .NUM_CHANNELS (NUM_CHANNELS)
  ) u_decode (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .word_i    (latched_reg),
    .on_i      (chan_on_reg),
    .chan_en_o (chan_en_o)
  );

  // Converter sequencer state
  mac_state_t            state_reg;
  mac_state_t            state_next;
  logic [1:0]            fall_cnt_reg;
  logic [1:0]            fall_cnt_next;
  logic [7:0]            samp_dly_reg;
  logic [7:0]            samp_dly_next;
  logic [3:0]            bit_idx_reg;
  logic [3:0]            bit_idx_next;
  logic [RESULT_BITS-1:0] sar_reg;
  logic [RESULT_BITS-1:0] sar_next;
  logic [RESULT_BITS-1:0] copy_reg;
  logic [RESULT_BITS-1:0] copy_next;
  logic [RESULT_BITS-1:0] result_reg;
  logic [RESULT_BITS-1:0] result_next;
  logic                  dout_reg;
  logic                  dout_next;
  logic                  oe_reg;
  logic                  oe_next;
  logic [RESULT_BITS-1:0] decided;

  // Sequencer next state; of the two selects only the converter select drives it
  always_comb
  begin
    state_next    = state_reg;
    fall_cnt_next = fall_cnt_reg;
    samp_dly_next = samp_dly_reg;
    bit_idx_next  = bit_idx_reg;
    sar_next      = sar_reg;
    copy_next     = copy_reg;
    result_next   = result_reg;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    // Comparator says input at or above trial keeps the bit
    decided       = sar_reg;
    decided[bit_idx_reg] = pins_s.comparator;
    case (state_reg)
      MAC_IDLE:
      begin
        // Start on select fall; drive the null level at once
        if (conv_fall)
        begin
          state_next    = MAC_SAMPLE;
          fall_cnt_next = 2'h0;
          samp_dly_next = 8'(SWITCH_ON_CYCLES);
          oe_next       = 1'b1;
          dout_next     = 1'b0;
        end
      end
      MAC_SAMPLE:
      begin
        if (samp_dly_reg != 8'h00)
          samp_dly_next = samp_dly_reg - 8'h01;
        if (sclk_fall)
        begin
          fall_cnt_next = fall_cnt_reg + 2'h1;
          // Second fall: hold and start the trial at mid scale
          if (fall_cnt_reg == HOLD_FALL_IDX)
          begin
            state_next   = MAC_CONVERT;
            bit_idx_next = 4'(RESULT_BITS - 1);
            sar_next     = {1'b1, {(RESULT_BITS-1){1'b0}}};
          end
        end
      end
      MAC_CONVERT:
      begin
        // One decision per falling edge, shown as it is made
        if (sclk_fall)
        begin
          dout_next = pins_s.comparator;
          if (bit_idx_reg == 4'h0)
          begin
            state_next  = MAC_TRAIL;
            sar_next    = decided;
            result_next = decided;
            // LSB already went out; copy starts with bit 1
            copy_next   = decided >> 1;
          end
          else
          begin
            sar_next     = decided;
            sar_next[bit_idx_reg - 4'h1] = 1'b1;
            bit_idx_next = bit_idx_reg - 4'h1;
          end
        end
      end
      MAC_TRAIL:
      begin
        // Powered down; copy shifts out, zeros follow
        if (sclk_fall)
        begin
          dout_next = copy_reg[0];
          copy_next = copy_reg >> 1;
        end
      end
      default:
        state_next = MAC_IDLE;
    endcase
    // Select high overrides everything: float and go idle
    if (pins_s.converter_select_n)
    begin
      state_next = MAC_IDLE;
      oe_next    = 1'b0;
      dout_next  = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg    <= MAC_IDLE;
      fall_cnt_reg <= 2'h0;
      samp_dly_reg <= 8'h00;
      bit_idx_reg  <= 4'h0;
      sar_reg      <= '0;
      copy_reg     <= '0;
      result_reg   <= '0;
      dout_reg     <= 1'b0;
      oe_reg       <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      fall_cnt_reg <= fall_cnt_next;
      samp_dly_reg <= samp_dly_next;
      bit_idx_reg  <= bit_idx_next;
      sar_reg      <= sar_next;
      copy_reg     <= copy_next;
      result_reg   <= result_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
    end
  end

  // Power only while sampling or converting
  always_comb
  begin
    analog_o.bias_on       = state_reg inside {MAC_SAMPLE, MAC_CONVERT};
    analog_o.ref_connect   = analog_o.bias_on;
    analog_o.sample        = state_reg == MAC_SAMPLE &&
                             samp_dly_reg == 8'h00;
    // Cap on the return input while converting
    analog_o.cap_to_return = state_reg == MAC_CONVERT;
  end

  assign trial_code_o = sar_reg;
  assign data_out_o   = dout_reg;
  assign data_oe_o    = oe_reg;

  // Wishbone slave: control, status and last result
  logic        ctrl_reg;
  logic        ctrl_next;
  logic        ack_reg;
  logic        ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wb_req;

  assign wb_req      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign ctrl_enable = ctrl_reg;

  // Bus next state; unmapped reads give zero, writes are dropped
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    ack_next   = wb_req;
    rdata_next = 32'h0000_0000;
    if (wb_req)
    begin
      case (wb_adr_i)
        REG_CTRL:
        begin
          rdata_next[CTRL_ENABLE_POS] = ctrl_reg;
          if (wb_we_i && wb_sel_i[0])
            ctrl_next = wb_dat_i[CTRL_ENABLE_POS];
        end
        REG_STATUS:
          rdata_next = {23'h000000, chan_on_reg, latched_reg,
                        word_reg[0], state_reg, oe_reg};
        REG_RESULT:
          rdata_next = {20'h00000, result_reg};
        default:
          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg  <= CTRL_RESET[0];
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // Checks
  a_float_high: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_s.converter_select_n |=> !data_oe_o && state_reg == MAC_IDLE)
    else $error("output not floated with select high");
  a_drive_soon: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    conv_fall |=> data_oe_o && !data_out_o)
    else $error("data line not taken after select fall");
  a_hold_edge: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == MAC_SAMPLE && sclk_fall && fall_cnt_reg == 2'h1 &&
    !pins_s.converter_select_n |=> state_reg == MAC_CONVERT)
    else $error("hold not on second falling edge");
  a_conv_end: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == MAC_CONVERT && sclk_fall && bit_idx_reg == 4'h0 &&
    !pins_s.converter_select_n |=> state_reg == MAC_TRAIL)
    else $error("conversion length wrong");
  a_power_down: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg inside {MAC_IDLE, MAC_TRAIL} |->
    !analog_o.bias_on && !analog_o.ref_connect)
    else $error("converter powered outside conversion");
  a_cap_return: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    $rose(state_reg == MAC_CONVERT) |->
    analog_o.cap_to_return && !analog_o.sample)
    else $error("cap not on return input at hold");
  a_msb_out: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == MAC_CONVERT && sclk_fall &&
    !pins_s.converter_select_n |=> data_out_o == $past(pins_s.comparator))
    else $error("decided bit not shown");
  a_word_shift: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_s.selector_select_n && sclk_rise |=>
    word_reg[0] == $past(pins_s.data_in))
    else $error("input bit not shifted");
  a_gate_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !latched_reg[GATE_POS] |=> chan_en_o == '0)
    else $error("channel on with gate low");
  a_break_first: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    sel_fall |=> ##1 chan_en_o == '0)
    else $error("no break before make");

  c_full_conv: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == MAC_CONVERT ##1 state_reg == MAC_TRAIL);
  c_chan_on: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    chan_on_reg && latched_reg[GATE_POS]);
  c_early_abort: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    state_reg == MAC_CONVERT ##1 state_reg == MAC_IDLE);

endmodule // mac_serial_ctrl

// ==== verification/mac_host_model.sv ====
// Host end of the serial link: shift clock, both selects, the shared
// data wire and an ideal analog input that answers the comparator.
module mac_host_model
  import mac_pkg::*;
(
  // Clock
  input  wire logic                            clock_i,
  // Device outputs seen by the host
  input  wire logic                            data_out_i,
  input  wire logic                            data_oe_i,
  input  wire mac_pkg::mac_analog_t            analog_i,
  input  wire logic [mac_pkg::RESULT_BITS-1:0] trial_code_i,
  input  wire logic [7:0]                      chan_en_i,
  // Pins towards the device
  output mac_pkg::mac_pins_t                   pins_o,
  // What the last frame showed
  output logic [27:0]                          bits_o,
  output logic [7:0]                           chan_o,
  output logic [6:0]                           flags_o,
  output logic                                 done_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;              // Half shift period, long vs sync
  logic                   sck;          // Shift clock
  logic                   sel_n;        // Selector select
  logic                   conv_n;       // Converter select
  logic                   din;          // Host data bit
  logic                   float_v;      // Changes every cycle when undriven
  logic [RESULT_BITS-1:0] vin;          // Analog level as an ideal code
  // Host drives only while the converter select is high
  wire logic host_oe = conv_n;
  wire logic line = host_oe ? din : (data_oe_i ? data_out_i : float_v);
  // Ideal comparator: 1 while the input is at or above the trial code
  assign pins_o = '{sck, sel_n, conv_n, line, (vin >= trial_code_i)};
  initial
  begin
    {sck, sel_n, conv_n, din, float_v, done_o} = 6'h1C;
    {vin, bits_o, chan_o, flags_o} = '0;
  end
  always @(posedge clock_i) float_v <= ~float_v;
  task automatic wait_half();
    repeat (HALF) @(posedge clock_i);
  endtask
  // One exchange: shift the word, run 28 clocks, read on rising edges
  task automatic frame(input logic [3:0] word, input logic [11:0] code,
                       input bit mux_too);
    logic [6:0]  f;
    logic [27:0] b;
    int          k;
    vin   <= code;
    // Converter-only frames leave the selector select where it stands
    if (mux_too)
      sel_n <= 1'b1;
    f = 7'h40;
    for (k = 0; k < WORD_BITS; k++)
    begin
      sck <= 1'b0;
      din <= word[WORD_BITS-1-k];
      wait_half();
      sck <= 1'b1;
      wait_half();
    end
    if (mux_too)
      sel_n <= 1'b0;
    conv_n <= 1'b0;
    // Clock stands still until the channel has settled
    repeat (SWITCH_ON_CYCLES + 24) @(posedge clock_i);
    for (k = 0; k < 28; k++)
    begin
      sck <= 1'b0;
      wait_half();
      sck <= 1'b1;
      b[k] = data_oe_i ? data_out_i : 1'b0;
      f[6] = f[6] & data_oe_i;
      if (k == 0)
      begin
        chan_o <= chan_en_i;
        f[3] = analog_i.sample;
      end
      if (k == 4)
        f[2:1] = {analog_i.bias_on & analog_i.ref_connect,
                  analog_i.cap_to_return};
      if (k == 19)
        f[0] = analog_i.bias_on | analog_i.ref_connect;
      wait_half();
    end
    conv_n <= 1'b1;
    if (mux_too)
      sel_n <= 1'b1;
    wait_half();
    f[5:4] = {~data_oe_i, analog_i.bias_on | analog_i.ref_connect};
    bits_o  <= b;
    flags_o <= f;
    done_o  <= 1'b1;
    @(posedge clock_i);
    done_o  <= 1'b0;
  endtask
endmodule // mac_host_model

// ==== verification/mac_serial_ctrl_test.sv ====
// Bench: host model on the link, Wishbone tasks on the registers
module mac_serial_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mac_pkg::*;
  typedef struct packed {
    logic [27:0] bits;
    logic [7:0]  chan;
    logic [6:0]  flags;
  } mac_frame_exp_t;
  logic           clock_i;
  logic           rst_n_i;
  mac_pins_t      pins;
  mac_analog_t    analog;
  logic           data_out;
  logic           data_oe;
  logic [11:0]    trial_code;
  logic [7:0]     chan_en;
  logic           wb_cyc;
  logic           wb_stb;
  logic           wb_we;
  logic [3:0]     wb_adr;
  logic [31:0]    wb_dat_i;
  logic [31:0]    wb_dat_o;
  logic           wb_ack;
  logic [27:0]    host_bits;
  logic [7:0]     host_chan;
  logic [6:0]     host_flags;
  logic           host_done;
  logic [7:0]     last_chan;        // Channel kept by the selector
  logic [31:0]    seed;
  int             num_errors;
  int             cmp_count;
  int             i;
  mac_frame_exp_t fr_exp;
  mac_frame_exp_t fr_q[$];          // Notes for frames in flight
  logic [31:0]    wb_q[$];          // Notes for reads in flight

  mac_serial_ctrl #(.NUM_CHANNELS(8)) u_mac_serial_ctrl (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .pins_i(pins),
    .data_out_o(data_out), .data_oe_o(data_oe), .analog_o(analog),
    .trial_code_o(trial_code), .chan_en_o(chan_en), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack));
  mac_host_model u_mac_host_model (
    .clock_i(clock_i), .data_out_i(data_out), .data_oe_i(data_oe),
    .analog_i(analog), .trial_code_i(trial_code), .chan_en_i(chan_en),
    .pins_o(pins), .bits_o(host_bits), .chan_o(host_chan),
    .flags_o(host_flags), .done_o(host_done));

  // Clock at 125 MHz
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s %0h, wanted %0h", $time, what,
               seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", cmp_count,
             num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Result leaves MSB first from the third rise, then the LSB-first copy
  function automatic logic [27:0] exp_bits(input logic [11:0] v);
    logic [27:0] b;
    b = '0;
    for (int k = 0; k < 12; k++)
      b[2 + k] = v[11 - k];
    for (int k = 1; k < 12; k++)
      b[13 + k] = v[k];
    return b;
  endfunction

  // Single cycle; waits for ack under a bound
  task automatic wb_cycle(input logic we, input logic [3:0] adr,
                          input logic [31:0] dat);
    int n;
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_i <= dat;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1)
    begin
      num_errors++;
      give_verdict();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wb_read(input logic [3:0] adr, input logic [31:0] exp);
    wb_q.push_back(exp);
    wb_cycle(1'b0, adr, 32'h0);
  endtask

  // Notes the expected frame, then lets the host run it
  task automatic run(input logic [3:0] word, input logic [11:0] code,
                     input bit mux_too, input bit on);
    mac_frame_exp_t e;
    if (mux_too)
      last_chan = word[3] ? (8'h01 << word[2:0]) : 8'h00;
    e.chan  = last_chan;
    e.bits  = on ? exp_bits(code) : 28'h0;
    e.flags = on ? 7'h6E : 7'h20;
    fr_q.push_back(e);
    u_mac_host_model.frame(word, code, mux_too);
  endtask

  // Watchers: compare each result with the oldest note
  always @(posedge clock_i)
  begin
    if (wb_ack && !wb_we)
      check(wb_dat_o, wb_q.pop_front(), "read");
    if (host_done)
    begin
      fr_exp = fr_q.pop_front();
      check(32'(host_bits), 32'(fr_exp.bits), "bits");
      check(32'(host_chan), 32'(fr_exp.chan), "chan");
      check(32'(host_flags), 32'(fr_exp.flags), "flags");
    end
  end

  // Hang guard
  initial
  begin
    repeat (100000) @(posedge clock_i);
    num_errors++;
    $display("unexpected at %0t: run timed out", $time);
    give_verdict();
  end

  initial
  begin
    {rst_n_i, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i} = '0;
    {num_errors, cmp_count, last_chan} = '0;
    seed = 32'h5E0B;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    wb_read(REG_CTRL, 32'h1);
    wb_read(4'hC, 32'h0);
    $display("test done: registers after reset");
    for (i = 0; i < 8; i++)
      run({1'b1, i[2:0]}, 12'($random(seed)), 1'b1, 1'b1);
    run(4'h6, 12'h000, 1'b1, 1'b1);
    run(4'hA, 12'hFFF, 1'b1, 1'b1);
    wb_read(REG_RESULT, 32'hFFF);
    $display("test done: all channel codes and gate off");
    // Converter select alone: new word must not reach the selector
    run(4'h3, 12'($random(seed)), 1'b0, 1'b1);
    run(4'hF, 12'($random(seed)), 1'b0, 1'b1);
    $display("test done: converter-only frames");
    wb_cycle(1'b1, REG_CTRL, 32'h0);
    wb_read(REG_CTRL, 32'h0);
    run(4'hD, 12'($random(seed)), 1'b1, 1'b0);
    wb_cycle(1'b1, REG_CTRL, 32'h1);
    run(4'h9, 12'($random(seed)), 1'b1, 1'b1);
    // Idle, floated, word 9 latched, last bit 1, channel still on
    wb_read(REG_STATUS, 32'h198);
    $display("test done: converter disabled and enabled again");
    repeat (4) @(posedge clock_i);
    give_verdict();
  end
endmodule // mac_serial_ctrl_test
